// ### i2c_seq_pkg.sv
package i2c_seq_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int          AXI_AW     = 6;        // byte address width
  localparam logic [5:0]  OFF_CTRL   = 6'h00;    // master control
  localparam logic [5:0]  OFF_STAT   = 6'h04;    // port status and flags
  localparam logic [5:0]  OFF_RELOAD = 6'h08;    // bit period reload
  localparam logic [5:0]  OFF_BUF    = 6'h0C;    // transfer buffer
  localparam logic [1:0]  RESP_OKAY  = 2'h0;     // normal answer
  localparam logic [1:0]  RESP_SLVERR = 2'h2;    // unmapped address

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_START   = 0;               // start request bit
  localparam int CTRL_RESTART = 1;               // restart request bit
  localparam int CTRL_RX      = 3;               // receive request bit
  localparam int CTRL_ACKSTAT = 6;               // ack received status
  localparam int STAT_BF      = 0;               // buffer full flag
  localparam int STAT_START   = 3;               // start detected
  localparam int STAT_WRITE_COLLISION_FLAG    = 4;               // write collision flag
  localparam int STAT_OVR     = 5;               // receive overrun flag
  localparam int STAT_EVT     = 6;               // port event flag
  localparam int STAT_BCL     = 7;               // bus collision flag

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [6:0] RELOAD_RST   = 7'h00;   // reload after reset
  localparam logic [0:0] QPHASE_LAST  = 1'h1;    // two sys clocks per tick
  localparam logic [3:0] LAST_TX_CLK  = 4'h8;    // ninth clock index
  localparam logic [3:0] LAST_RX_CLK  = 4'h7;    // eighth clock index

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_ST_WAIT, S_ST_HOLD, S_RS_SCLLOW, S_RS_SDAREL, S_RS_RISE,
    S_RS_HIGH, S_RS_HOLD, S_FALL, S_LOW, S_RISE, S_HIGH, S_RX_DONE
  } seq_state_t;

endpackage

// ### brg_if.sv
`timescale 1ns/1ns
interface brg_if;
  logic       load;    // one-cycle reload request
  logic [6:0] reload;  // value to load
  logic       expire;  // one-cycle pulse at count end
  modport master  (output load, output reload, input expire);
  modport counter (input load, input reload, output expire);
endinterface

// ### bit_period_counter.sv
`timescale 1ns/1ns
module bit_period_counter
  import i2c_seq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // sequencer side
  brg_if.counter   brg
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [0:0] phase;   // tick divider
    logic [6:0] count;   // remaining ticks
    logic       busy;    // counting
    logic       expire;  // end pulse
  } brg_reg_t;

  brg_reg_t r;           // registered state
  brg_reg_t n;           // next state
  logic     tick;        // decrement enable

  // down-count twice per instruction cycle, stop at zero
  always_comb begin
    n = r;
    n.expire = 1'b0;
    tick = (r.phase == QPHASE_LAST);
    n.phase = tick ? 1'h0 : 1'h1;
    if (brg.load) begin
      n.count = brg.reload;
      n.busy = 1'b1;
    end else if (r.busy && tick) begin
      if (r.count == 7'h00) begin
        n.busy = 1'b0;
        n.expire = 1'b1;
      end else begin
        n.count = 7'(r.count - 7'h01);
      end
    end
    if (!rst_b) begin
      n = '0;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    r <= n;
  end

  assign brg.expire = r.expire;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // a reload in the same cycle wins over the stop, so it is left out here
  a_cnt_stops: assert property (r.busy && r.count == 7'h00 && tick && !brg.load
      |=> !r.busy && r.expire)
    else $error("counter did not stop at zero");
  c_cnt_expire: cover property (r.expire);

endmodule

// ### i2c_master_sequencer.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module i2c_master_sequencer
  import i2c_seq_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  // register bus, write side
  input  wire logic [i2c_seq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // register bus, read side
  input  wire logic [i2c_seq_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // open-drain lines
  input  wire logic                    sclIn,
  output logic                         sclOut,
  output logic                         sclOeB,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOeB
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    seq_state_t  st;                 // sequencer state
    logic        rxMode;             // shifting in, not out
    logic [3:0]  bitCnt;             // clocks completed
    logic [7:0]  shiftR;             // shift register
    logic [7:0]  bufR;               // transfer buffer
    logic [6:0]  reload;             // bit period reload
    logic        startReq;           // start request bit
    logic        restartReq;         // restart request bit
    logic        rxReq;              // receive request bit
    logic        ackStat;            // ack received status
    logic        bf;                 // buffer full flag
    logic        startSeen;          // start detected
    logic        write_collision_flag;               // write collision flag
    logic        ovr;                // receive overrun flag
    logic        evt;                // port event flag
    logic        bcl;                // bus collision flag
    logic        sclOeB;             // low pulls SCL
    logic        sdaOeB;             // low pulls SDA
    logic        sclO;               // line level when pulled
    logic        sdaO;               // line level when pulled
    logic        sclS1, sclS2;       // SCL synchroniser
    logic        sdaS1, sdaS2;       // SDA synchroniser
    logic        sdaPrev;            // SDA one cycle back
    logic        brgLoad;            // counter reload pulse
    logic        awRdy, wRdy;        // write channel readies
    logic        awGot, wGot;        // halves of a write held
    logic [5:0]  awAddr;             // held write address
    logic [7:0]  wData;              // held write byte
    logic        wStb;               // held byte enable
    logic        bValid;             // write answer
    logic [1:0]  bResp;              // write answer code
    logic        arRdy;              // read address ready
    logic        rValid;             // read answer
    logic [31:0] rData;              // read data
    logic [1:0]  rResp;              // read answer code
  } seq_reg_t;

  seq_reg_t r;                       // registered state
  seq_reg_t n;                       // next state
  logic     sclHigh;                 // synchronised SCL
  logic     sdaHigh;                 // synchronised SDA
  logic     busy;                    // any event under way
  logic     seqBusy;                 // start or restart under way
  logic     wrDo;                    // write performed this cycle
  logic     wrBuf;                   // write aims at the buffer

  brg_if brg ();                     // counter link

  bit_period_counter u_brg (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .brg     (brg.counter)
  );

  assign brg.load   = r.brgLoad;
  assign brg.reload = r.reload;

  // abort any bus event on collision
  function automatic seq_reg_t collide(input seq_reg_t s);
    seq_reg_t c;
    c = s;
    c.bcl = 1'b1;
    c.sclOeB = 1'b1;
    c.sdaOeB = 1'b1;
    c.startReq = 1'b0;
    c.restartReq = 1'b0;
    c.rxReq = 1'b0;
    c.bf = 1'b0;
    c.st = S_IDLE;
    return c;
  endfunction

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    n.brgLoad = 1'b0;
    sclHigh = r.sclS2;
    sdaHigh = r.sdaS2;
    // pins pass two flip-flops before use
    n.sclS1 = sclIn;
    n.sclS2 = r.sclS1;
    n.sdaS1 = sdaIn;
    n.sdaS2 = r.sdaS1;
    n.sdaPrev = r.sdaS2;
    seqBusy = (r.st inside {S_ST_WAIT, S_ST_HOLD, S_RS_SCLLOW, S_RS_SDAREL,
                            S_RS_RISE, S_RS_HIGH, S_RS_HOLD});
    busy = (r.st != S_IDLE) || r.startReq || r.restartReq || r.rxReq;
    wrDo = r.awGot && r.wGot;
    wrBuf = ({r.awAddr[5:2], 2'h0} == OFF_BUF);

    // write channels: take address and data in either order
    if (s_axi_awvalid && r.awRdy) begin
      n.awGot = 1'b1;
      n.awRdy = 1'b0;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wRdy) begin
      n.wGot = 1'b1;
      n.wRdy = 1'b0;
      n.wData = s_axi_wdata[7:0];
      n.wStb = s_axi_wstrb[0];
    end
    if (r.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
      n.awRdy = 1'b1;
      n.wRdy = 1'b1;
    end

    // register write, flags clear before hardware sets below
    if (wrDo) begin
      n.awGot = 1'b0;
      n.wGot = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      case ({r.awAddr[5:2], 2'h0})
        OFF_CTRL: begin
          if (r.wStb && !busy) begin
            n.startReq = r.wData[CTRL_START];
            n.restartReq = r.wData[CTRL_RESTART];
            n.rxReq = r.wData[CTRL_RX];
          end
        end
        OFF_STAT: begin
          if (r.wStb) begin
            // write one to clear; only software clears these
            n.startSeen = r.startSeen & ~r.wData[STAT_START];
            n.write_collision_flag = r.write_collision_flag & ~r.wData[STAT_WRITE_COLLISION_FLAG];
            n.ovr = r.ovr & ~r.wData[STAT_OVR];
            n.evt = r.evt & ~r.wData[STAT_EVT];
            n.bcl = r.bcl & ~r.wData[STAT_BCL];
          end
        end
        OFF_RELOAD: begin
          if (r.wStb) begin
            n.reload = r.wData[6:0];
          end
        end
        OFF_BUF: begin
          if (!r.wStb) begin
            // no byte enabled: nothing stored
          end else if (busy) begin
            n.write_collision_flag = 1'b1;
          end else begin
            n.bufR = r.wData;
            n.shiftR = r.wData;
            n.bf = 1'b1;
            n.rxMode = 1'b0;
            n.bitCnt = 4'h0;
            n.sclOeB = 1'b0;
            n.st = S_FALL;
          end
        end
        default: n.bResp = RESP_SLVERR;
      endcase
    end

    // register read; buffer read while idle clears the full flag
    if (r.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
      n.arRdy = 1'b1;
    end
    if (s_axi_arvalid && r.arRdy) begin
      n.arRdy = 1'b0;
      n.rValid = 1'b1;
      n.rResp = RESP_OKAY;
      n.rData = 32'h0000_0000;
      case ({s_axi_araddr[5:2], 2'h0})
        OFF_CTRL: begin
          n.rData[CTRL_START] = r.startReq;
          n.rData[CTRL_RESTART] = r.restartReq;
          n.rData[CTRL_RX] = r.rxReq;
          n.rData[CTRL_ACKSTAT] = r.ackStat;
        end
        OFF_STAT: begin
          n.rData[STAT_BF] = r.bf;
          n.rData[STAT_START] = r.startSeen;
          n.rData[STAT_WRITE_COLLISION_FLAG] = r.write_collision_flag;
          n.rData[STAT_OVR] = r.ovr;
          n.rData[STAT_EVT] = r.evt;
          n.rData[STAT_BCL] = r.bcl;
        end
        OFF_RELOAD: n.rData[6:0] = r.reload;
        OFF_BUF: begin
          n.rData[7:0] = r.bufR;
          if (r.st == S_IDLE) begin
            n.bf = 1'b0;
          end
        end
        default: n.rResp = RESP_SLVERR;
      endcase
    end

    // start condition seen on the lines during a start or restart
    if (r.sdaPrev && !sdaHigh && sclHigh && seqBusy) begin
      n.startSeen = 1'b1;
    end

    // sequencer
    case (r.st)
      S_IDLE: begin
        if (r.startReq) begin
          if (sclHigh && sdaHigh) begin
            n.brgLoad = 1'b1;
            n.st = S_ST_WAIT;
          end else begin
            n = collide(n);
          end
        end else if (r.restartReq) begin
          n.sclOeB = 1'b0;
          n.st = S_RS_SCLLOW;
        end else if (r.rxReq) begin
          n.rxMode = 1'b1;
          n.bitCnt = 4'h0;
          n.sclOeB = 1'b0;
          n.st = S_FALL;
        end
      end
      // start: both lines high for one period
      S_ST_WAIT: begin
        if (!sclHigh) begin
          n = collide(n);
        end else if (brg.expire) begin
          if (sdaHigh) begin
            n.sdaOeB = 1'b0;
            n.brgLoad = 1'b1;
            n.st = S_ST_HOLD;
          end else begin
            n = collide(n);
          end
        end
      end
      S_ST_HOLD: begin
        if (brg.expire) begin
          n.startReq = 1'b0;
          n.evt = 1'b1;
          n.st = S_IDLE;
        end
      end
      // restart: SCL low, then release SDA for a period
      S_RS_SCLLOW: begin
        if (!sclHigh) begin
          n.brgLoad = 1'b1;
          n.sdaOeB = 1'b1;
          n.st = S_RS_SDAREL;
        end
      end
      S_RS_SDAREL: begin
        if (brg.expire) begin
          if (sdaHigh) begin
            n.sclOeB = 1'b1;
            n.st = S_RS_RISE;
          end else begin
            n = collide(n);
          end
        end
      end
      S_RS_RISE: begin
        if (sclHigh) begin
          if (!sdaHigh) begin
            n = collide(n);
          end else begin
            n.brgLoad = 1'b1;
            n.st = S_RS_HIGH;
          end
        end
      end
      S_RS_HIGH: begin
        if (!sclHigh || !sdaHigh) begin
          n = collide(n);
        end else if (brg.expire) begin
          n.sdaOeB = 1'b0;
          n.brgLoad = 1'b1;
          n.st = S_RS_HOLD;
        end
      end
      S_RS_HOLD: begin
        if (brg.expire) begin
          n.restartReq = 1'b0;
          n.evt = 1'b1;
          n.st = S_IDLE;
        end
      end
      // shift: SCL low phase starts once SCL is seen low
      S_FALL: begin
        if (!sclHigh) begin
          if (r.rxMode) begin
            n.sdaOeB = 1'b1;
          end else if (r.bitCnt == LAST_TX_CLK) begin
            n.sdaOeB = 1'b1;
            n.bf = 1'b0;
          end else begin
            n.sdaOeB = r.shiftR[7];
            n.shiftR = {r.shiftR[6:0], 1'b0};
          end
          n.brgLoad = 1'b1;
          n.st = S_LOW;
        end
      end
      S_LOW: begin
        if (brg.expire) begin
          n.sclOeB = 1'b1;
          n.st = S_RISE;
        end
      end
      S_RISE: begin
        if (sclHigh) begin
          n.brgLoad = 1'b1;
          n.st = S_HIGH;
        end
      end
      S_HIGH: begin
        if (brg.expire) begin
          n.sclOeB = 1'b0;
          if (r.rxMode) begin
            n.shiftR = {r.shiftR[6:0], sdaHigh};
            n.bitCnt = 4'(r.bitCnt + 4'h1);
            n.st = (r.bitCnt == LAST_RX_CLK) ? S_RX_DONE : S_FALL;
          end else if (r.bitCnt == LAST_TX_CLK) begin
            n.ackStat = sdaHigh;
            n.evt = 1'b1;
            n.st = S_IDLE;
          end else begin
            n.bitCnt = 4'(r.bitCnt + 4'h1);
            n.st = S_FALL;
          end
        end
      end
      S_RX_DONE: begin
        if (!sclHigh) begin
          n.bufR = r.shiftR;
          n.bf = 1'b1;
          n.ovr = n.ovr | r.bf;                     // keeps a same-cycle clear
          n.rxReq = 1'b0;
          n.evt = 1'b1;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase

    // synchronous reset ends any transfer
    if (!rst_b) begin
      n = '0;
      n.st = S_IDLE;
      n.sclOeB = 1'b1;
      n.sdaOeB = 1'b1;
      n.awRdy = 1'b1;
      n.wRdy = 1'b1;
      n.arRdy = 1'b1;
      n.reload = RELOAD_RST;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    r <= n;
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign s_axi_awready = r.awRdy;
  assign s_axi_wready  = r.wRdy;
  assign s_axi_bvalid  = r.bValid;
  assign s_axi_bresp   = r.bResp;
  assign s_axi_arready = r.arRdy;
  assign s_axi_rvalid  = r.rValid;
  assign s_axi_rdata   = r.rData;
  assign s_axi_rresp   = r.rResp;
  assign sclOeB        = r.sclOeB;
  assign sdaOeB        = r.sdaOeB;
  assign sclOut        = r.sclO;   // never set: pulled low only
  assign sdaOut        = r.sdaO;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_start_load: assert property (r.st == S_IDLE && r.startReq && sclHigh && sdaHigh
      |=> r.brgLoad && r.st == S_ST_WAIT)
    else $error("start did not load counter");
  a_start_pull: assert property (r.st == S_ST_WAIT && brg.expire && sclHigh && sdaHigh
      |=> !r.sdaOeB && r.sclOeB ##1 r.st == S_ST_HOLD)
    else $error("start did not pull SDA");
  a_start_end: assert property (r.st == S_ST_HOLD && brg.expire
      |=> !r.startReq && r.evt && !r.sdaOeB && r.st == S_IDLE)
    else $error("start did not complete");
  a_start_coll: assert property (r.st == S_IDLE && r.startReq && !(sclHigh && sdaHigh)
      |=> r.bcl && r.st == S_IDLE && !r.startReq)
    else $error("start collision missed");
  a_write_collision_flag_set: assert property (wrDo && wrBuf && r.wStb && busy
      |=> r.write_collision_flag && r.bufR == $past(r.bufR))
    else $error("busy buffer write not refused");
  a_write_collision_flag_keep: assert property (r.write_collision_flag && !wrDo |=> r.write_collision_flag)
    else $error("write collision cleared by hardware");
  a_tx_ack: assert property (r.st == S_HIGH && !r.rxMode && r.bitCnt == LAST_TX_CLK
      && brg.expire |=> r.ackStat == $past(sdaHigh) && r.evt && !r.sclOeB)
    else $error("acknowledge not sampled");
  a_rx_done: assert property (r.st == S_RX_DONE && !sclHigh
      |=> r.bf && !r.rxReq && r.evt && r.bufR == $past(r.shiftR) && r.st == S_IDLE)
    else $error("receive completion wrong");
  a_scl_wait: assert property (r.st == S_RISE && !sclHigh |=> !r.brgLoad)
    else $error("counter started while SCL low");

  c_start: cover property (r.st == S_ST_HOLD && brg.expire);
  c_restart: cover property (r.st == S_RS_HOLD && brg.expire);
  c_tx_byte: cover property (r.st == S_HIGH && !r.rxMode && r.bitCnt == LAST_TX_CLK);
  c_rx_byte: cover property (r.st == S_RX_DONE && !sclHigh);

endmodule

// ### i2c_slave_model.sv
`timescale 1ns/1ns
// --------------------------------------------------
// far-side slave: acks, captures, sends a byte
// --------------------------------------------------
module i2c_slave_model (
  // bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour controls
  input  wire logic       ackEn,
  input  wire logic       rxMode,
  input  wire logic [7:0] rxByte,
  // pull and capture
  output logic            sdaOeB,
  output logic [7:0]      got
);
  int cnt = 0;  // clock rises within the byte
  initial begin
    sdaOeB = 1'b1;
    got = 8'h00;
  end
  // a start condition restarts the bit count
  always @(negedge sda) if (scl) cnt = 0;
  // data is valid while scl is high
  always @(posedge scl) begin
    if (cnt < 8) got = {got[6:0], sda};
    cnt = cnt + 1;
  end
  // the line changes while scl is low, or when rxMode rises
  always @(negedge scl or posedge rxMode) begin
    if (rxMode) begin
      if (cnt >= 8) cnt = 0;
      sdaOeB = rxByte[7-cnt];
    end else begin
      if (cnt == 9) cnt = 0;
      sdaOeB = !(cnt == 8 && ackEn);
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import i2c_seq_pkg::*;
  logic sys_clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [1:0] bresp, rresp, rp;
  logic awready, wready, bvalid, arready, rvalid, sclOut, sclOeB, sdaOut, sdaOeB, slvOeB;
  logic ackEn = 1, rxMode = 0;
  logic [7:0] rxByte = 0, got, d;
  int failures = 0, comparisons = 0;
  logic [7:0] exq[$];          // bytes the model expects, oldest first
  wire scl = sclOeB;           // pull-up, master alone drives clock
  wire sda = sdaOeB & slvOeB;  // wired-and with pull-up
  always #5 sys_clk = ~sys_clk;
  i2c_master_sequencer i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclIn(scl),
    .sclOut(sclOut), .sclOeB(sclOeB), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeB(sdaOeB));
  i2c_slave_model i_slave (.scl(scl), .sda(sda), .ackEn(ackEn), .rxMode(rxMode),
    .rxByte(rxByte), .sdaOeB(slvOeB), .got(got));
  // register write: each channel dropped once taken
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // register read into rv and rp
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata; rp = rresp; rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // poll status until the event flag shows, bounded
  task automatic waitev();
    bit seen = 1'b0;
    repeat (300) begin
      rd(OFF_STAT);
      if (rv[STAT_EVT] === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    // a poll limit that runs out is a mismatch
    if (!seen) begin
      failures++;
      $display("[FAIL] %0t event flag never set", $time);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #600000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(32'h23a4f3ab));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_STAT); chk(rv, 0);
    rd(6'h10); chk({30'h0, rp}, {30'h0, RESP_SLVERR});
    wr(OFF_RELOAD, 8'h03); rd(OFF_RELOAD); chk(rv, 3);
    $display("test registers done");
    // start, then queued buffer and control writes refused
    wr(OFF_CTRL, 8'h01); wr(OFF_BUF, 8'h5A); wr(OFF_CTRL, 8'h0A); waitev();
    rd(OFF_CTRL); chk(rv[3:0], 0);
    rd(OFF_STAT); chk(rv[7:0], 8'h58);
    chk({sdaOeB, sclOeB, sdaOut}, 3'b010);
    wr(OFF_STAT, 8'hF8);
    $display("test start done");
    // transmit with ack then without
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom); ackEn <= (k == 0);
      exq.push_back(d);  // only the write made while idle goes out
      wr(OFF_BUF, d); rd(OFF_STAT); chk(rv[0], 1);
      wr(OFF_BUF, ~d); waitev();
      rd(OFF_CTRL); chk(rv[CTRL_ACKSTAT], k);
      rd(OFF_STAT); chk(rv[7:0], 8'h50);
      chk({got, sclOeB}, {exq.pop_front(), 1'b0});
      wr(OFF_STAT, 8'hF8);
    end
    $display("test transmit done");
    wr(OFF_CTRL, 8'h02); waitev();
    rd(OFF_CTRL); chk(rv[1:0], 0);
    rd(OFF_STAT); chk(rv[7:0], 8'h48);
    chk(sdaOeB, 0);
    wr(OFF_STAT, 8'hF8);
    $display("test restart done");
    // receive twice without reading: overrun
    d = 8'($urandom); rxByte <= d; rxMode <= 1'b1;
    exq.push_back(d);
    wr(OFF_CTRL, 8'h08); waitev(); rd(OFF_STAT); chk(rv[7:0], 8'h41);
    exq.push_back(d);
    wr(OFF_STAT, 8'hF8); wr(OFF_CTRL, 8'h08); waitev();
    rd(OFF_STAT); chk(rv[7:0], {2'b01, exq.size() > 1, 5'h01});
    rd(OFF_BUF); chk(rv[7:0], exq[$]);
    exq.delete();
    rd(OFF_STAT); chk(rv[0], 0);
    $display("test receive done");
    // start while SCL is held low: bus collision, lines released
    wr(OFF_STAT, 8'hF8);
    wr(OFF_CTRL, 8'h01);
    rd(OFF_STAT); chk(rv[7:0], 8'h80);
    rd(OFF_CTRL); chk(rv[0], 0);
    chk({sdaOeB, sclOeB}, 2'b11);
    $display("test collision done");
    // reset in the middle of a byte ends it
    wr(OFF_BUF, 8'($urandom));
    repeat (40) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_STAT); chk(rv, 0);
    chk({sdaOeB, sclOeB}, 2'b11);
    $display("test reset done");
    close_out();
  end
endmodule
